// file: design/spf_pkg.sv
/*
  spf_pkg: register map, field positions, reset values, timing counts,
  state types and the shared parity function of the serial channel.
  assumes: one 200 MHz system clock; Avalon-MM byte addresses, one word
  per register, 8-bit data in the low byte.
*/
package spf_pkg;

  // register byte offsets
  localparam logic [4:0] OFF_TX_CTL = 5'h00;
  localparam logic [4:0] OFF_RX_CTL = 5'h04;
  localparam logic [4:0] OFF_BUF0   = 5'h08;
  localparam logic [4:0] OFF_BUF1   = 5'h0C;
  localparam logic [4:0] OFF_BUF2   = 5'h10;
  localparam logic [4:0] OFF_BUF3   = 5'h14;
  localparam logic [4:0] OFF_STAT0  = 5'h18;
  localparam logic [4:0] OFF_RING   = 5'h1C;

  // reset values and writable masks (other bits are fixed)
  localparam logic [7:0] TX_CTL_RST   = 8'h8A;
  localparam logic [7:0] TX_CTL_WMASK = 8'h75;
  localparam logic [7:0] RX_CTL_RST   = 8'h12;
  localparam logic [7:0] RX_CTL_WMASK = 8'hED;
  localparam logic [7:0] STAT0_RST    = 8'h00;

  // control field positions (mode, address, parity shared; stop transmit only; ring, enable receive only)
  localparam int B_MODE = 0;
  localparam int B_ADDR = 2;
  localparam int B_RING = 3;
  localparam int B_STOP = 4;
  localparam int B_PEN  = 5;
  localparam int B_EVEN = 6;
  localparam int B_REN  = 7;

  // status register zero field positions
  localparam int B_FERR = 0;
  localparam int B_OERR = 1;
  localparam int B_PERR = 2;
  localparam int B_MERR = 3;
  localparam int B_RXRQ = 5;
  localparam int B_TXRQ = 7;

  // bit timing in system clocks
  localparam logic [7:0] BIT_LAST  = 8'h0F;
  localparam logic [7:0] HALF_LAST = 8'h07;

  typedef enum logic [1:0] {
    SPF_RX_IDLE,
    SPF_RX_START,
    SPF_RX_BITS,
    SPF_RX_STOP
  } spf_rx_state_t;

  // parity bit for a data byte; even=0 selects odd parity
  function automatic logic spf_parity(input logic [7:0] d,
                                      input logic       even);
    spf_parity = even ? (^d) : ~(^d);
  endfunction : spf_parity

endpackage : spf_pkg

// file: design/spf_rx.sv
/*
  spf_rx: frame deserialiser for the receive line, with pin synchroniser.
  assumes: rxd is asynchronous; settings are stable while enable is high.
*/
`timescale 1ns/1ps
`default_nettype none
module spf_rx (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       rxd,
  input  wire logic       enable,
  input  wire logic       mp_mode,
  input  wire logic       par_en,
  input  wire logic       par_even,
  output var  logic       done,
  output var  logic [7:0] data,
  output var  logic       mpc,
  output var  logic       perr,
  output var  logic       ferr
);
  logic                   s1_reg, s2_reg;
  spf_pkg::spf_rx_state_t st_reg;
  logic [9:0]             sh_reg;
  logic [3:0]             cnt_reg;
  logic [7:0]             tick_reg;
  logic [3:0]             nbits;
  logic [9:0]             algn;
  logic                   pbit;

  // two-stage pin synchroniser
  always_ff @(posedge clk_sys) begin
    s1_reg <= rxd;
    s2_reg <= s1_reg;
  end

  // align the captured bits so data sits at bit 0
  always_comb begin
    nbits = 4'h8 + {3'h0, mp_mode} + {3'h0, par_en};
    algn  = sh_reg >> (4'hA - nbits);
    pbit  = mp_mode ? algn[9] : algn[8];
  end

  // start check at mid-bit, then sample each bit centre
  always_ff @(posedge clk_sys) begin
    done <= 1'b0;
    if (srst || !enable) begin
      st_reg <= spf_pkg::SPF_RX_IDLE;
      tick_reg <= 8'h00;
      cnt_reg  <= 4'h0;
      if (srst) begin
        data <= 8'h00;
        mpc  <= 1'b0;
        perr <= 1'b0;
        ferr <= 1'b0;
        sh_reg <= 10'h000;
      end
    end else if (tick_reg != 8'h00) begin
      tick_reg <= tick_reg - 8'h01;
    end else begin
      unique case (st_reg)
        spf_pkg::SPF_RX_IDLE: if (!s2_reg) begin
          st_reg   <= spf_pkg::SPF_RX_START;
          tick_reg <= spf_pkg::HALF_LAST;
        end
        spf_pkg::SPF_RX_START: begin
          st_reg   <= s2_reg ? spf_pkg::SPF_RX_IDLE : spf_pkg::SPF_RX_BITS;
          tick_reg <= spf_pkg::BIT_LAST;
          cnt_reg  <= nbits;
        end
        spf_pkg::SPF_RX_BITS: begin
          sh_reg   <= {s2_reg, sh_reg[9:1]};
          cnt_reg  <= cnt_reg - 4'h1;
          tick_reg <= spf_pkg::BIT_LAST;
          if (cnt_reg == 4'h1) st_reg <= spf_pkg::SPF_RX_STOP;
        end
        spf_pkg::SPF_RX_STOP: begin
          st_reg <= spf_pkg::SPF_RX_IDLE;
          done   <= 1'b1;
          data   <= algn[7:0];
          mpc    <= mp_mode & algn[8];
          perr   <= par_en &
                    (pbit != spf_pkg::spf_parity(algn[7:0], par_even));
          ferr   <= ~s2_reg;
        end
      endcase
    end
  end
endmodule : spf_rx
`default_nettype wire

// file: design/spf_serial_port.sv
/*
  spf_serial_port: serial channel with single-buffer transmit and a
  single or four-stage ring receive path, registers on Avalon-MM.
  assumes: one synchronous clock; txd/rxd go to a remote serial node;
  the bus master holds each request until waitrequest is low.
*/
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module spf_serial_port (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  input  wire logic        rxd,
  output var  logic        txd
);
  logic [7:0] tx_ctl_reg;
  logic [7:0] rx_ctl_reg;
  logic [7:0] stat0_reg;
  logic [7:0] stat0_next;
  logic [7:0] buf_reg [4];
  logic [7:0] tx_buf_reg;
  logic       tx_full_reg;
  logic [1:0] ring_ptr_reg;
  logic       unread0_reg;
  logic       req;
  logic       acc;
  logic       wr_acc;
  logic       rd_acc;
  logic [7:0] rmux;
  logic       tx_busy;
  logic       tx_start;
  logic       rx_done;
  logic [7:0] rx_data;
  logic       rx_mpc;
  logic       rx_perr;
  logic       rx_ferr;
  logic       rx_mp;
  logic       accept;
  logic [1:0] target;
  logic       to_buf0;
  logic       merr;

  // bus request phases: first cycle wait, second cycle takes effect
  assign req    = avs_read | avs_write;
  assign acc    = req & ~avs_waitrequest;
  assign wr_acc = acc & avs_write & avs_byteenable[0];
  assign rd_acc = acc & avs_read;

  // receive acceptance and destination buffer
  assign rx_mp   = rx_ctl_reg[spf_pkg::B_MODE];
  assign accept  = rx_done &
                   ~(rx_mp & rx_ctl_reg[spf_pkg::B_ADDR] & ~rx_mpc);
  assign target  = rx_ctl_reg[spf_pkg::B_RING] ? ring_ptr_reg
                                               : 2'h0;
  assign to_buf0 = accept & (target == 2'h0);
  assign merr    = rx_mp & ~rx_ctl_reg[spf_pkg::B_ADDR] & rx_mpc;
  assign tx_start = tx_full_reg & ~tx_busy;

  // waitrequest from a flop: one wait cycle per request
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
    end
  end

  // read mux; fixed control bits read as one, unmapped reads zero
  always_comb begin
    unique case (avs_address)
      spf_pkg::OFF_TX_CTL: rmux = tx_ctl_reg;
      spf_pkg::OFF_RX_CTL: rmux = rx_ctl_reg;
      spf_pkg::OFF_BUF0:   rmux = buf_reg[0];
      spf_pkg::OFF_BUF1:   rmux = buf_reg[1];
      spf_pkg::OFF_BUF2:   rmux = buf_reg[2];
      spf_pkg::OFF_BUF3:   rmux = buf_reg[3];
      spf_pkg::OFF_STAT0:  rmux = stat0_reg;
      spf_pkg::OFF_RING:   rmux = {6'h00, ring_ptr_reg};
      default:             rmux = 8'h00;
    endcase
  end

  // read data captured in the wait cycle, stands at the taking edge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (req & avs_waitrequest) begin
      avs_readdata <= {24'h00_0000, rmux};
    end
  end

  // control registers; only writable bits change
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_ctl_reg <= spf_pkg::TX_CTL_RST;
      rx_ctl_reg <= spf_pkg::RX_CTL_RST;
    end else if (wr_acc) begin
      if (avs_address == spf_pkg::OFF_TX_CTL) begin
        tx_ctl_reg <= (avs_writedata[7:0] & spf_pkg::TX_CTL_WMASK) |
                      (spf_pkg::TX_CTL_RST & ~spf_pkg::TX_CTL_WMASK);
      end
      if (avs_address == spf_pkg::OFF_RX_CTL) begin
        rx_ctl_reg <= (avs_writedata[7:0] & spf_pkg::RX_CTL_WMASK) |
                      (spf_pkg::RX_CTL_RST & ~spf_pkg::RX_CTL_WMASK);
      end
    end
  end

  // single transmit buffer, loaded by a write to buffer 0
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_buf_reg  <= 8'h00;
      tx_full_reg <= 1'b0;
    end else if (wr_acc && avs_address == spf_pkg::OFF_BUF0) begin
      tx_buf_reg  <= avs_writedata[7:0];
      tx_full_reg <= 1'b1;
    end else if (tx_start) begin
      tx_full_reg <= 1'b0;
    end
  end

  // receive buffers: buffer 0 alone or the four-entry ring
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ring_ptr_reg <= 2'h0;
    end else if (accept) begin
      buf_reg[target] <= rx_data;
      if (rx_ctl_reg[spf_pkg::B_RING]) begin
        ring_ptr_reg <= ring_ptr_reg + 2'h1;
      end
    end
  end

  // buffer 0 unread marker; a new byte wins over a read
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      unread0_reg <= 1'b0;
    end else if (to_buf0) begin
      unread0_reg <= 1'b1;
    end else if (rd_acc && avs_address == spf_pkg::OFF_BUF0) begin
      unread0_reg <= 1'b0;
    end
  end

  // status zero: software write, then hardware sets win
  always_comb begin
    stat0_next = stat0_reg;
    if (wr_acc && avs_address == spf_pkg::OFF_STAT0) begin
      stat0_next = avs_writedata[7:0];
    end
    if (rx_done && rx_ferr) begin
      stat0_next[spf_pkg::B_FERR] = 1'b1;
    end
    if (to_buf0 && unread0_reg) begin
      stat0_next[spf_pkg::B_OERR] = 1'b1;
    end
    if (to_buf0 && rx_perr) begin
      stat0_next[spf_pkg::B_PERR] = 1'b1;
    end
    if (to_buf0 && merr) begin
      stat0_next[spf_pkg::B_MERR] = 1'b1;
    end
    if (accept) begin
      stat0_next[spf_pkg::B_RXRQ] = 1'b1;
    end
    if (tx_start) begin
      stat0_next[spf_pkg::B_TXRQ] = 1'b1;
    end
  end

  // sticky status register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stat0_reg <= spf_pkg::STAT0_RST;
    end else begin
      stat0_reg <= stat0_next;
    end
  end

  // transmit serialiser
  spf_tx u_tx (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .start    (tx_start),
    .data     (tx_buf_reg),
    .mp_mode  (tx_ctl_reg[spf_pkg::B_MODE]),
    .mpc      (tx_ctl_reg[spf_pkg::B_ADDR]),
    .one_stop (tx_ctl_reg[spf_pkg::B_STOP]),
    .par_en   (tx_ctl_reg[spf_pkg::B_PEN]),
    .par_even (tx_ctl_reg[spf_pkg::B_EVEN]),
    .txd      (txd),
    .busy     (tx_busy)
  );

  // receive deserialiser
  spf_rx u_rx (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .rxd      (rxd),
    .enable   (rx_ctl_reg[spf_pkg::B_REN]),
    .mp_mode  (rx_mp),
    .par_en   (rx_ctl_reg[spf_pkg::B_PEN]),
    .par_even (rx_ctl_reg[spf_pkg::B_EVEN]),
    .done     (rx_done),
    .data     (rx_data),
    .mpc      (rx_mpc),
    .perr     (rx_perr),
    .ferr     (rx_ferr)
  );

  // checks on reset values, flags and buffers
  property p_tx_reset;
    @(posedge clk_sys) srst |=> tx_ctl_reg == spf_pkg::TX_CTL_RST;
  endproperty
  a_tx_reset: assert property (p_tx_reset)
    else $error("transmit control reset value wrong");

  property p_rx_reset;
    @(posedge clk_sys) srst |=> (rx_ctl_reg == spf_pkg::RX_CTL_RST)
      && !rx_ctl_reg[spf_pkg::B_REN];
  endproperty
  a_rx_reset: assert property (p_rx_reset)
    else $error("receive control reset value wrong");

  property p_stat_reset;
    @(posedge clk_sys) srst |=> stat0_reg == spf_pkg::STAT0_RST;
  endproperty
  a_stat_reset: assert property (p_stat_reset)
    else $error("status zero not cleared by reset");

  property p_overrun;
    @(posedge clk_sys) disable iff (srst)
      to_buf0 && unread0_reg |=> stat0_reg[spf_pkg::B_OERR];
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");

  property p_store;
    @(posedge clk_sys) disable iff (srst)
      accept |=> buf_reg[$past(target)] == $past(rx_data);
  endproperty
  a_store: assert property (p_store)
    else $error("received byte not stored");

  property p_ignored;
    @(posedge clk_sys) disable iff (srst)
      rx_done && !accept && !stat0_reg[spf_pkg::B_RXRQ] && !wr_acc
      |=> $stable(buf_reg[0]) && !stat0_reg[spf_pkg::B_RXRQ];
  endproperty
  a_ignored: assert property (p_ignored)
    else $error("ignored frame changed state");

  property p_ring;
    @(posedge clk_sys) disable iff (srst)
      accept && rx_ctl_reg[spf_pkg::B_RING]
      |=> ring_ptr_reg == 2'($past(ring_ptr_reg) + 2'h1);
  endproperty
  a_ring: assert property (p_ring)
    else $error("ring pointer did not advance");

  property p_ferr;
    @(posedge clk_sys) disable iff (srst)
      rx_done && rx_ferr |=> stat0_reg[spf_pkg::B_FERR];
  endproperty
  a_ferr: assert property (p_ferr)
    else $error("framing error not flagged");

  property p_rxrq;
    @(posedge clk_sys) disable iff (srst)
      accept |=> stat0_reg[spf_pkg::B_RXRQ];
  endproperty
  a_rxrq: assert property (p_rxrq)
    else $error("receive request not raised");

  property p_txrq;
    @(posedge clk_sys) disable iff (srst)
      tx_start |=> stat0_reg[spf_pkg::B_TXRQ] && tx_busy;
  endproperty
  a_txrq: assert property (p_txrq)
    else $error("transmit request not raised");

  property p_perr;
    @(posedge clk_sys) disable iff (srst)
      to_buf0 && rx_perr |=> stat0_reg[spf_pkg::B_PERR];
  endproperty
  a_perr: assert property (p_perr)
    else $error("parity error not flagged");

  property p_merr;
    @(posedge clk_sys) disable iff (srst)
      to_buf0 && merr |=> stat0_reg[spf_pkg::B_MERR];
  endproperty
  a_merr: assert property (p_merr)
    else $error("multiprocessor error not flagged");

  property p_idle_high;
    @(posedge clk_sys) disable iff (srst)
      !tx_busy |-> txd;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("transmit line not high while idle");

  property p_disabled;
    @(posedge clk_sys) disable iff (srst)
      !rx_ctl_reg[spf_pkg::B_REN] [*2] |-> !rx_done;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("reception while disabled");

  property p_wait;
    @(posedge clk_sys) disable iff (srst)
      req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait)
    else $error("waitrequest sequence wrong");

endmodule : spf_serial_port
`default_nettype wire

// file: design/spf_tx.sv
/*
  spf_tx: single-buffered frame serialiser for the transmit line.
  assumes: start is a one-cycle pulse taken only while busy is low.
*/
`timescale 1ns/1ps
`default_nettype none
module spf_tx (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       start,
  input  wire logic [7:0] data,
  input  wire logic       mp_mode,
  input  wire logic       mpc,
  input  wire logic       one_stop,
  input  wire logic       par_en,
  input  wire logic       par_even,
  output var  logic       txd,
  output var  logic       busy
);
  logic [12:0] sh_reg;
  logic [3:0]  left_reg;
  logic [7:0]  tick_reg;
  logic [3:0]  ext;
  logic        par;
  logic [12:0] frame;
  logic [3:0]  len;

  // start, data lsb first, mp bit, parity, stop bits
  always_comb begin
    par = spf_pkg::spf_parity(data, par_even);
    unique case ({mp_mode, par_en})
      2'b00:   ext = 4'hF;
      2'b01:   ext = {3'h7, par};
      2'b10:   ext = {3'h7, mpc};
      default: ext = {2'h3, par, mpc};
    endcase
    frame = {ext, data, 1'b0};
    len = 4'h9 + {3'h0, mp_mode} + {3'h0, par_en}
        + (one_stop ? 4'h1 : 4'h2);
  end

  // shift one bit per bit period, idle high
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      txd      <= 1'b1;
      busy     <= 1'b0;
      sh_reg   <= '1;
      left_reg <= 4'h0;
      tick_reg <= 8'h00;
    end else if (!busy) begin
      if (start) begin
        txd      <= frame[0];
        sh_reg   <= {1'b1, frame[12:1]};
        left_reg <= len;
        tick_reg <= spf_pkg::BIT_LAST;
        busy     <= 1'b1;
      end
    end else if (tick_reg != 8'h00) begin
      tick_reg <= tick_reg - 8'h01;
    end else begin
      tick_reg <= spf_pkg::BIT_LAST;
      left_reg <= left_reg - 4'h1;
      if (left_reg == 4'h1) begin
        busy <= 1'b0;
        txd  <= 1'b1;
      end else begin
        txd    <= sh_reg[0];
        sh_reg <= {1'b1, sh_reg[12:1]};
      end
    end
  end
endmodule : spf_tx
`default_nettype wire

// file: dv/spf_remote_node.sv
/*
  spf_remote_node: remote serial node facing the serial channel.
  assumes: 16 system clocks per bit; the bench calls send and cap.
*/
`timescale 1ns/1ps
`default_nettype none
module spf_remote_node (
  input  wire logic clk_sys,
  output var  logic rxd,
  input  wire logic txd
);
  int cyc = 0;

  // free cycle count, times the start of frames
  always @(posedge clk_sys) cyc <= cyc + 1;

  initial rxd = 1'b1;

  // frame length in bits for a control byte
  function automatic int flen(input logic [7:0] c);
    return 11 + int'(c[0]) + int'(c[5]) - int'(c[4]);
  endfunction : flen

  // frame bits, start bit first, tail left high as stop bits
  function automatic logic [12:0] fbits(input logic [7:0] d,
                                        input logic [7:0] c);
    logic [12:0] f;
    int          n;
    f      = '1;
    f[0]   = 1'b0;
    f[8:1] = d;
    n      = 9;
    if (c[0]) begin
      f[n] = c[2];
      n    = n + 1;
    end
    if (c[5]) begin
      f[n] = c[6] ? ^d : ~^d;
    end
    return f;
  endfunction : fbits

  // drive one frame on the receive line, back to idle high after
  task automatic send(input logic [12:0] f, input int n);
    @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat (16) @(posedge clk_sys);
    end
    rxd <= 1'b1;
  endtask : send

  // capture n bits of the transmit line at mid-bit
  task automatic cap(input int n, output logic [12:0] f, output int t);
    int k;
    f = '1;
    k = 0;
    while (txd !== 1'b0 && k < 4000) begin
      @(posedge clk_sys);
      k++;
    end
    t = (k < 4000) ? cyc : -1;  // -1 marks a start bit that never came
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      f[i] = txd;
      if (i < n - 1) repeat (16) @(posedge clk_sys);
    end
  endtask : cap
endmodule : spf_remote_node
`default_nettype wire

// file: dv/tb_serial_port_four_stage_rx.sv
/*
  tb_serial_port_four_stage_rx: self-checking bench of the serial channel.
  assumes: spf_pkg and the design files compiled first; remote node model.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_serial_port_four_stage_rx;
  typedef struct {
    logic [7:0] c;
    logic [7:0] d;
    logic [7:0] rb;
    int         n;
  } spf_row_t;

  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        rxd;
  logic        txd;
  logic [3:0]  be_v = 4'hF;
  logic [7:0]  rdv;
  logic [12:0] f0;
  logic [12:0] f1;
  int          t0;
  int          t1;
  int          n_errors = 0;
  int          check_count = 0;
  // control, data, control read back, frame length
  spf_row_t    rows [7] = '{
    '{8'h00, 8'hA5, 8'h8A, 11}, '{8'h10, 8'h3C, 8'h9A, 10},
    '{8'h30, 8'h81, 8'hBA, 11}, '{8'h60, 8'h7E, 8'hEA, 12},
    '{8'h05, 8'hC3, 8'h8F, 12}, '{8'h11, 8'h5A, 8'h9B, 11},
    '{8'h75, 8'h0F, 8'hFF, 12}};

  always #2.5 clk_sys = ~clk_sys;

  spf_serial_port dut_u (
    .clk_sys         (clk_sys),
    .srst            (srst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .rxd             (rxd),
    .txd             (txd)
  );

  spf_remote_node node_u (
    .clk_sys (clk_sys),
    .rxd     (rxd),
    .txd     (txd)
  );

  task automatic finish_test();
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic is_wr, input logic [4:0] a,
                     input logic [7:0] wd);
    int k;
    @(posedge clk_sys);
    avs_address    <= a;
    avs_write      <= is_wr;
    avs_read       <= ~is_wr;
    avs_writedata  <= {24'h0, wd};
    avs_byteenable <= be_v;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 64);
    rdv = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      $display("BAD %0t bus timeout", $time);
      n_errors++;
      finish_test();
    end
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] e,
                    input logic [7:0] m = 8'hFF);
    bus(1'b0, a, 8'h00);
    chk(13'(rdv & m), 13'(e));
  endtask : rd

  // receive settings change only with the receiver switched off first
  task automatic rxc(input logic [7:0] c);
    wr(spf_pkg::OFF_RX_CTL, 8'h00);
    wr(spf_pkg::OFF_RX_CTL, c);
    rd(spf_pkg::OFF_RX_CTL, (c & 8'hED) | 8'h12);
  endtask : rxc

  // send a frame, check status and buffer zero, then clear status
  task automatic rxchk(input logic [7:0] d, input logic [7:0] c,
                       input logic [12:0] flip, input logic rb,
                       input logic [7:0] es, input logic [7:0] eb);
    node_u.send(node_u.fbits(d, c) ^ flip, node_u.flen(c));
    rd(spf_pkg::OFF_STAT0, es, 8'h2F);
    if (rb) rd(spf_pkg::OFF_BUF0, eb);
    wr(spf_pkg::OFF_STAT0, 8'h00);
  endtask : rxchk

  // main sequence: rows first, then reset and awkward cases
  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    foreach (rows[i]) begin
      wr(spf_pkg::OFF_TX_CTL, rows[i].c);
      rd(spf_pkg::OFF_TX_CTL, rows[i].rb);
      fork
        begin
          node_u.cap(rows[i].n, f0, t0);
          node_u.cap(rows[i].n, f1, t1);
        end
        begin
          wr(spf_pkg::OFF_BUF0, rows[i].d);
          wr(spf_pkg::OFF_BUF0, ~rows[i].d);
          rd(spf_pkg::OFF_STAT0, 8'h80, 8'h80);
        end
      join
      if (t0 < 0 || t1 < 0) begin
        n_errors++;
        $display("BAD %0t transmit frame never started", $time);
        finish_test();
      end
      chk(f0, node_u.fbits(rows[i].d, rows[i].c));
      chk(f1, node_u.fbits(~rows[i].d, rows[i].c));
      chk(13'((t1 - t0) / 16), 13'(rows[i].n));
      rxc(8'h80 | (rows[i].c & 8'h65));
      rxchk(rows[i].d, rows[i].c, 13'h0000, 1'b1, 8'h20,
            rows[i].d);
    end
    // second reset with registers dirty
    wr(spf_pkg::OFF_STAT0, 8'hFF);
    srst <= 1'b1;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    rd(spf_pkg::OFF_TX_CTL, 8'h8A);
    rd(spf_pkg::OFF_RX_CTL, 8'h12);
    rd(spf_pkg::OFF_STAT0, 8'h00);
    chk(13'(txd), 13'h0001);
    be_v = 4'h0;
    wr(spf_pkg::OFF_TX_CTL, 8'h00);
    be_v = 4'hF;
    wr(5'h02, 8'hFF);
    rd(5'h02, 8'h00);
    rd(spf_pkg::OFF_TX_CTL, 8'h8A);
    // ring of four buffers, five frames so buffer zero wraps
    rxc(8'h88);
    for (int i = 1; i <= 5; i++) begin
      node_u.send(node_u.fbits(8'(8'h11 * i), 8'h00), 11);
    end
    wr(spf_pkg::OFF_BUF1, 8'hEE);
    for (int j = 1; j <= 3; j++) begin
      rd(spf_pkg::OFF_BUF0 + 5'(4 * j), 8'(8'h11 * (j + 1)));
    end
    rd(spf_pkg::OFF_RING, 8'h01);
    rd(spf_pkg::OFF_STAT0, 8'h22, 8'h2F);
    rd(spf_pkg::OFF_BUF0, 8'h55);
    wr(spf_pkg::OFF_STAT0, 8'h00);
    // overrun in single mode, flag recurs when cleared unread
    rxc(8'h80);
    rxchk(8'hA1, 8'h00, 13'h0000, 1'b0, 8'h20, 8'h00);
    rxchk(8'hB2, 8'h00, 13'h0000, 1'b0, 8'h22, 8'h00);
    rxchk(8'hC3, 8'h00, 13'h0000, 1'b1, 8'h22, 8'hC3);
    rxc(8'hA0);
    rxchk(8'hD4, 8'h20, 13'h200, 1'b1, 8'h24, 8'hD4);
    rxchk(8'hE5, 8'h20, 13'h400, 1'b1, 8'h21, 8'hE5);
    rxc(8'h81);
    rxchk(8'h96, 8'h05, 13'h0000, 1'b1, 8'h28, 8'h96);
    rxc(8'h85);
    rxchk(8'h69, 8'h01, 13'h0000, 1'b1, 8'h00, 8'h96);
    rxc(8'h00);
    rxchk(8'h5A, 8'h00, 13'h0000, 1'b1, 8'h00, 8'h96);
    finish_test();
  end
endmodule : tb_serial_port_four_stage_rx
`default_nettype wire
